/* File: design/operand_addressing_decode.sv */
// What this block does
// - the 3-bit register field picks B,C,D,E,H,L or A, code 110 none.
// - general pairs are BC,DE,HL,stack; push/pop code 11 is acc-flag.
// - index pair fields pick BC,DE,index reg,stack; hi/lo picks a byte.
// - register indirect takes the address from BC, DE or HL.
// - indexed adds a sign-extended displacement to the index register.
// - extended takes the address from two instruction bytes.
// - immediate takes the value from instruction bytes, no memory access.
// - relative only serves branches: target is pc plus displacement.
// - only i/o accesses drive the i/o request strobe low.
// - first i/o form: operand on low byte, accumulator on high byte.
// - second i/o form: B on low byte, C on high byte.
// - third i/o form: operand on low byte, high byte zero.
// - fourth i/o form: C on low byte, high byte zero.
// - implied mode selects its register from impl_sel alone, except IMPL_GENERAL, which uses the register field.
`include "opdec_map.svh"
module operand_addressing_decode (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire opdec_pkg::dec_req_t REQ,
  input wire opdec_pkg::reg_view_t REGS,
  output opdec_pkg::dec_out_t RESULT,
  output logic [15:0] ADDR_OUT,
  output logic io_request_strobe_n
);
  import opdec_pkg::*;

  dec_out_t out_reg, out_next;
  logic strobe_reg, strobe_next;
  logic [15:0] io_addr_w;

  function automatic logic [7:0] reg_onehot(input logic [2:0] code);
    logic [7:0] v;
    v = `ZERO_BYTE;
    if (code != `REG_CODE_NONE) begin
      v[code] = 1'b1;
    end
    return v;
  endfunction : reg_onehot

  function automatic pair_sel_t pair_decode(input pair_kind_t kind,
                                            input logic [1:0] f);
    pair_sel_t p;
    case (f)
      `PAIR_CODE_0: p = PAIR_BC;
      `PAIR_CODE_1: p = PAIR_DE;
      `PAIR_CODE_2: p = (kind == FIELD_FIRST_INDEX) ? PAIR_IDX_FIRST :
                        (kind == FIELD_SECOND_INDEX) ? PAIR_IDX_SECOND :
                        PAIR_HL;
      `PAIR_CODE_3: p = (kind == FIELD_PUSHPOP) ? PAIR_ACC_FLAG : PAIR_STACK;
      default: p = PAIR_BC;
    endcase
    return p;
  endfunction : pair_decode

  function automatic logic [15:0] pair_value(input pair_sel_t p,
                                             input reg_view_t r);
    logic [15:0] v;
    case (p)
      PAIR_BC: v = {r.b, r.c};
      PAIR_DE: v = {r.d, r.e};
      PAIR_HL: v = {r.h, r.l};
      PAIR_STACK: v = r.stack_pointer_reg;
      PAIR_ACC_FLAG: v = {r.acc, r.flags};
      PAIR_IDX_FIRST: v = r.index_reg_first;
      PAIR_IDX_SECOND: v = r.index_reg_second;
      default: v = `ZERO_WORD;
    endcase
    return v;
  endfunction : pair_value

  function automatic logic [15:0] sext_add(input logic [15:0] base,
                                           input logic [7:0] disp);
    logic [15:0] wide_disp;
    wide_disp = {{8{disp[`SIGN_BIT]}}, disp};
    return base + wide_disp;
  endfunction : sext_add

  io_addr_form u_io_form (
    .form(REQ.io_form),
    .operand(REQ.byte0),
    .acc(REGS.acc),
    .reg_b(REGS.b),
    .reg_c(REGS.c),
    .addr(io_addr_w)
  );

  always_comb begin
    pair_sel_t psel;
    logic [15:0] idx;
    psel = pair_decode(REQ.pair_kind, REQ.pair_field);
    idx = REQ.idx_second ? REGS.index_reg_second : REGS.index_reg_first;
    out_next = '0;
    strobe_next = `IO_STROBE_IDLE;
    if (REQ.valid) begin
      out_next.valid = 1'b1;
      out_next.reg_sel = reg_onehot(REQ.reg_field);
      out_next.reg_none = (REQ.reg_field == `REG_CODE_NONE);
      out_next.pair_sel[psel] = 1'b1;
      out_next.byte_hi = REQ.pair_hi;
      out_next.byte_lo = REQ.pair_lo & ~REQ.pair_hi;
      case (REQ.mode)
        MODE_IMPLIED: begin
          out_next.reg_sel = `ZERO_BYTE;
          out_next.reg_none = 1'b0;
          out_next.pair_sel = '0;
          case (REQ.impl_sel)
            IMPL_ACC: out_next.reg_sel[`REG_CODE_A] = 1'b1;
            IMPL_IDX_FIRST: out_next.pair_sel[PAIR_IDX_FIRST] = 1'b1;
            IMPL_IDX_SECOND: out_next.pair_sel[PAIR_IDX_SECOND] = 1'b1;
            IMPL_STACK: out_next.pair_sel[PAIR_STACK] = 1'b1;
            IMPL_GENERAL: out_next.reg_sel = reg_onehot(REQ.reg_field);
            default: out_next.reg_none = 1'b1;
          endcase
        end
        MODE_REG_INDIRECT: begin
          if (psel == PAIR_BC || psel == PAIR_DE || psel == PAIR_HL) begin
            out_next.mem_access = 1'b1;
            out_next.mem_addr = pair_value(psel, REGS);
          end
        end
        MODE_INDEXED: begin
          out_next.mem_access = 1'b1;
          out_next.mem_addr = sext_add(idx, REQ.byte0);
        end
        MODE_EXTENDED: begin
          out_next.mem_access = 1'b1;
          out_next.mem_addr = {REQ.byte1, REQ.byte0};
        end
        MODE_IMMEDIATE: begin
          out_next.imm_valid = 1'b1;
          out_next.imm_value = {REQ.byte1, REQ.byte0};
        end
        MODE_RELATIVE: begin
          out_next.branch_valid = 1'b1;
          out_next.branch_target = sext_add(REGS.pc, REQ.byte0);
        end
        MODE_IO: begin
          out_next.io_access = 1'b1;
          out_next.io_addr = io_addr_w;
          strobe_next = `IO_STROBE_ACTIVE;
        end
        default: begin
          out_next.mem_access = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      out_reg <= '0;
      strobe_reg <= `IO_STROBE_IDLE;
    end else begin
      out_reg <= out_next;
      strobe_reg <= strobe_next;
    end
  end

  assign RESULT = out_reg;
  // one address bus, io address wins when strobe active
  assign ADDR_OUT = out_reg.io_access ? out_reg.io_addr :
                    out_reg.branch_valid ? out_reg.branch_target :
                    out_reg.mem_addr;
  assign io_request_strobe_n = strobe_reg;
endmodule : operand_addressing_decode

/* File: design/opdec_map.svh */
`ifndef OPDEC_MAP_SVH
`define OPDEC_MAP_SVH
`define REG_CODE_B 3'h0
`define REG_CODE_C 3'h1
`define REG_CODE_D 3'h2
`define REG_CODE_E 3'h3
`define REG_CODE_H 3'h4
`define REG_CODE_L 3'h5
`define REG_CODE_NONE 3'h6
`define REG_CODE_A 3'h7
`define PAIR_CODE_0 2'h0
`define PAIR_CODE_1 2'h1
`define PAIR_CODE_2 2'h2
`define PAIR_CODE_3 2'h3
`define ZERO_BYTE 8'h00
`define ZERO_WORD 16'h0000
`define IO_STROBE_ACTIVE 1'b0
`define IO_STROBE_IDLE 1'b1
`define SIGN_BIT 7
`endif

/* File: design/opdec_pkg.sv */
package opdec_pkg;
  typedef enum logic [3:0] {
    MODE_NONE = 4'h0,
    MODE_IMPLIED = 4'h1,
    MODE_REG_INDIRECT = 4'h2,
    MODE_INDEXED = 4'h3,
    MODE_EXTENDED = 4'h4,
    MODE_IMMEDIATE = 4'h5,
    MODE_RELATIVE = 4'h6,
    MODE_IO = 4'h7
  } addr_mode_t;

  typedef enum logic [1:0] {
    FIELD_GENERAL = 2'h0,
    FIELD_PUSHPOP = 2'h1,
    FIELD_FIRST_INDEX = 2'h2,
    FIELD_SECOND_INDEX = 2'h3
  } pair_kind_t;

  typedef enum logic [1:0] {
    IO_OPND_ACC = 2'h0,
    IO_B_C = 2'h1,
    IO_OPND_ZERO = 2'h2,
    IO_C_ZERO = 2'h3
  } io_form_t;

  typedef enum logic [2:0] {
    IMPL_NONE = 3'h0,
    IMPL_ACC = 3'h1,
    IMPL_IDX_FIRST = 3'h2,
    IMPL_IDX_SECOND = 3'h3,
    IMPL_STACK = 3'h4,
    IMPL_GENERAL = 3'h5
  } impl_sel_t;

  typedef enum logic [2:0] {
    PAIR_BC = 3'h0,
    PAIR_DE = 3'h1,
    PAIR_HL = 3'h2,
    PAIR_STACK = 3'h3,
    PAIR_ACC_FLAG = 3'h4,
    PAIR_IDX_FIRST = 3'h5,
    PAIR_IDX_SECOND = 3'h6
  } pair_sel_t;

  // one decode request from the fetch stage
  typedef struct packed {
    logic valid;
    addr_mode_t mode;
    logic [2:0] reg_field;
    logic [1:0] pair_field;
    pair_kind_t pair_kind;
    logic pair_hi;
    logic pair_lo;
    logic idx_second;
    io_form_t io_form;
    impl_sel_t impl_sel;
    logic [7:0] byte0;
    logic [7:0] byte1;
  } dec_req_t;

  // register file contents
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] flags;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] h;
    logic [7:0] l;
    logic [15:0] index_reg_first;
    logic [15:0] index_reg_second;
    logic [15:0] stack_pointer_reg;
    logic [15:0] pc;
  } reg_view_t;

  // registered decode result
  typedef struct packed {
    logic valid;
    logic [7:0] reg_sel;
    logic reg_none;
    logic [6:0] pair_sel;
    logic byte_hi;
    logic byte_lo;
    logic mem_access;
    logic [15:0] mem_addr;
    logic imm_valid;
    logic [15:0] imm_value;
    logic branch_valid;
    logic [15:0] branch_target;
    logic io_access;
    logic [15:0] io_addr;
  } dec_out_t;
endpackage : opdec_pkg

/* File: design/io_addr_form.sv */
`include "opdec_map.svh"
module io_addr_form (
  input wire opdec_pkg::io_form_t form,
  input wire logic [7:0] operand,
  input wire logic [7:0] acc,
  input wire logic [7:0] reg_b,
  input wire logic [7:0] reg_c,
  output logic [15:0] addr
);
  import opdec_pkg::*;
  always_comb begin
    case (form)
      IO_OPND_ACC: addr = {acc, operand};
      IO_B_C: addr = {reg_c, reg_b};
      IO_OPND_ZERO: addr = {`ZERO_BYTE, operand};
      IO_C_ZERO: addr = {`ZERO_BYTE, reg_c};
      default: addr = `ZERO_WORD;
    endcase
  end
endmodule : io_addr_form

/* File: verif/opdec_chk.sv */
module opdec_chk
  import opdec_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire opdec_pkg::dec_req_t REQ,
  input wire opdec_pkg::reg_view_t REGS,
  input wire opdec_pkg::dec_out_t RESULT,
  input wire logic [15:0] ADDR_OUT,
  input wire logic io_request_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  wire logic io_go = REQ.valid && REQ.mode == MODE_IO;
  wire logic [1:0] fm = REQ.io_form;
  wire logic [7:0] b0 = REQ.byte0;
  chk_strobe_low: assert property (
    io_go |=> !io_request_strobe_n) else $error("strobe not low");
  chk_form_acc: assert property (
    io_go && fm == 2'h0 |=> ADDR_OUT == {$past(REGS.acc), $past(b0)})
    else $error("io form 0 address");
  chk_form_bc: assert property (
    io_go && fm == 2'h1 |=> ADDR_OUT == {$past(REGS.c), $past(REGS.b)})
    else $error("io form 1 address");
  chk_form_opnd: assert property (
    io_go && fm == 2'h2 |=> ADDR_OUT == {8'h00, $past(b0)})
    else $error("io form 2 address");
  chk_form_czero: assert property (
    io_go && fm == 2'h3 |=> ADDR_OUT == {8'h00, $past(REGS.c)})
    else $error("io form 3 address");
  chk_ext_addr: assert property (
    REQ.valid && REQ.mode == MODE_EXTENDED |=> RESULT.mem_access
    && RESULT.mem_addr == {$past(REQ.byte1), $past(b0)})
    else $error("extended address");
  chk_imm_nomem: assert property (
    REQ.valid && REQ.mode == MODE_IMMEDIATE |=> RESULT.imm_valid
    && !RESULT.mem_access) else $error("immediate made access");
  chk_none_sel: assert property (
    REQ.valid && REQ.mode == MODE_NONE && REQ.reg_field == 3'h6
    |=> RESULT.reg_none && RESULT.reg_sel == 8'h00)
    else $error("code 110 selected");
  cover property (io_go);
  cover property (REQ.valid && REQ.mode == MODE_INDEXED);
  cover property (RESULT.branch_valid);
endmodule : opdec_chk

bind operand_addressing_decode opdec_chk chk_u (
  .REF_CLK(REF_CLK),
  .SYS_RST(SYS_RST),
  .REQ(REQ),
  .REGS(REGS),
  .RESULT(RESULT),
  .ADDR_OUT(ADDR_OUT),
  .io_request_strobe_n(io_request_strobe_n)
);

/* File: verif/regfile_model.sv */
module regfile_model
  import opdec_pkg::*;
(
  input wire logic clk,
  input wire logic upd,
  output opdec_pkg::reg_view_t regs
);
  timeunit 1ns;
  timeprecision 1ps;
  initial regs = '0;
  // new contents each edge while upd is set, so stale operands show
  always @(posedge clk) begin
    if (upd)
      regs <= {$urandom, $urandom, $urandom, $urandom};
  end
endmodule : regfile_model

/* File: verif/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import opdec_pkg::*;
  // preset so time zero brings no false edge
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic upd;
  dec_req_t req;
  dec_req_t p;
  reg_view_t regs;
  reg_view_t pr;
  dec_out_t res;
  logic [15:0] addr;
  logic strb_n;
  int fails;
  int total_checks;
  regfile_model rf_u (.clk(clk), .upd(upd), .regs(regs));
  operand_addressing_decode dut_u (.REF_CLK(clk), .SYS_RST(rst),
    .REQ(req), .REGS(regs), .RESULT(res), .ADDR_OUT(addr),
    .io_request_strobe_n(strb_n));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // what the decoder took at this edge
  always @(posedge clk) begin
    p <= req;
    pr <= regs;
  end
  task automatic chk(input string n, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  function automatic logic [15:0] sx(input logic [7:0] d);
    return {{8{d[7]}}, d};
  endfunction : sx
  task automatic check_one();
    logic [15:0] ea;
    logic [15:0] ix;
    logic [2:0] pi;
    logic [2:0] f;
    logic ck;
    logic is_io;
    logic is_rel;
    logic [15:0] ip;
    f = p.reg_field;
    pi = {1'b0, p.pair_field};
    if (pi == 3 && p.pair_kind == FIELD_PUSHPOP) pi = 4;
    if (pi == 2 && p.pair_kind == FIELD_FIRST_INDEX) pi = 5;
    if (pi == 2 && p.pair_kind == FIELD_SECOND_INDEX) pi = 6;
    ix = p.idx_second ? pr.index_reg_second : pr.index_reg_first;
    ck = p.mode inside {MODE_INDEXED, MODE_EXTENDED, MODE_RELATIVE, MODE_IO}
      || (p.mode == MODE_REG_INDIRECT && pi < 3);
    ea = pi == 0 ? {pr.b, pr.c} : pi == 1 ? {pr.d, pr.e} : {pr.h, pr.l};
    is_io = p.valid && p.mode == MODE_IO;
    is_rel = p.valid && p.mode == MODE_RELATIVE;
    chk("valid", 16'(res.valid), 16'(p.valid));
    chk("strobe", 16'(strb_n), 16'(!is_io));
    chk("io", 16'(res.io_access), 16'(is_io));
    chk("br", 16'(res.branch_valid), 16'(is_rel));
    if (!p.valid) begin
      chk("idle", 16'(res != '0), 16'h0);
      ck = 0;
    end else case (p.mode)
      MODE_NONE: begin
        chk("reg", 16'(res.reg_sel), f == 6 ? 16'h0 : 16'h1 << f);
        chk("none", 16'(res.reg_none), 16'(f == 6));
        chk("pair", 16'(res.pair_sel), 16'h1 << pi);
        chk("hi", 16'(res.byte_hi), 16'(p.pair_hi));
        chk("lo", 16'(res.byte_lo), 16'(p.pair_lo && !p.pair_hi));
      end
      MODE_IMPLIED: begin
        ip = p.impl_sel == IMPL_IDX_FIRST ? 16'h20 :
          p.impl_sel == IMPL_IDX_SECOND ? 16'h40 :
          p.impl_sel == IMPL_STACK ? 16'h8 : 16'h0;
        chk("implp", 16'(res.pair_sel), ip);
        ip = p.impl_sel == IMPL_ACC ? 16'h80 : 16'h0;
        if (p.impl_sel == IMPL_GENERAL && f != 6) ip = 16'h1 << f;
        chk("impl", 16'(res.reg_sel), ip);
        chk("impln", 16'(res.reg_none), 16'(p.impl_sel == IMPL_NONE));
      end
      MODE_REG_INDIRECT: chk("ind", 16'(res.mem_access), 16'(pi < 3));
      MODE_INDEXED: ea = ix + sx(p.byte0);
      MODE_EXTENDED: ea = {p.byte1, p.byte0};
      MODE_IMMEDIATE: begin
        chk("imm", res.imm_value, {p.byte1, p.byte0});
        chk("immem", 16'(res.mem_access), 16'h0);
      end
      MODE_RELATIVE: ea = pr.pc + sx(p.byte0);
      MODE_IO: case (p.io_form)
        IO_OPND_ACC: ea = {pr.acc, p.byte0};
        IO_B_C: ea = {pr.c, pr.b};
        IO_OPND_ZERO: ea = {8'h00, p.byte0};
        default: ea = {8'h00, pr.c};
      endcase
      default: ck = 0;
    endcase
    if (ck) chk("addr", addr, ea);
  endtask : check_one
  always @(negedge clk) begin
    if (!rst) check_one();
    else chk("rst", 16'({res != '0, strb_n}), 16'h1);
  end
  function automatic dec_req_t rnd_req();
    dec_req_t r;
    r = 36'({$urandom, $urandom});
    r.valid = $urandom_range(3) != 0;
    r.mode = addr_mode_t'($urandom_range(7));
    r.impl_sel = impl_sel_t'($urandom_range(5));
    return r;
  endfunction : rnd_req
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    rst = 1;
    upd = 0;
    req = '0;
    fails = 0;
    total_checks = 0;
    void'($urandom(89));
    repeat (5) @(posedge clk);
    rst <= 0;
    upd <= 1;
    // second pass follows a mid-run reset
    repeat (2) begin
      repeat (3000) begin
        @(posedge clk);
        req <= rnd_req();
      end
      @(posedge clk);
      rst <= 1;
      req <= '0;
      repeat (3) @(posedge clk);
      rst <= 0;
    end
    @(posedge clk);
    wrap_up();
  end
endmodule : testbench
